// ### common/lcdhrm_map.svh
// constants of the display host core: command fields, sizes, timing
// assumes a 20 MHz core clock
`ifndef LCDHRM_MAP_SVH
`define LCDHRM_MAP_SVH

`define LCDHRM_CLK_MHZ      20
`define LCDHRM_T_FAST_US    125
`define LCDHRM_T_SLOW_US    175
`define LCDHRM_CYC_FAST     (`LCDHRM_T_FAST_US * `LCDHRM_CLK_MHZ)
`define LCDHRM_CYC_SLOW     (`LCDHRM_T_SLOW_US * `LCDHRM_CLK_MHZ)

`define LCDHRM_LINE_LEN     4'hC
`define LCDHRM_LINE_LAST    4'hB
`define LCDHRM_DD_DEPTH     24
`define LCDHRM_CG_DEPTH     32
`define LCDHRM_ICON_BASE    5'h14
`define LCDHRM_ICON_WORDS   12
`define LCDHRM_CURSOR_ROW   3'h7
`define LCDHRM_RESET_AC     7'h00

// command class is given by the position of the leading one
`define LCDHRM_OP_DDADDR    7
`define LCDHRM_OP_CGADDR    6
`define LCDHRM_OP_SHIFT     4
`define LCDHRM_OP_DISPCTL   3
`define LCDHRM_OP_ENTRY     2
`define LCDHRM_OP_HOME      1
`define LCDHRM_SC_BIT       3
`define LCDHRM_RL_BIT       2

`endif

// ### common/lcdhrm_pkg.sv
// shared types of the display host core
// assumes nothing beyond a SystemVerilog compiler
package lcdhrm_pkg;
    typedef enum logic [2:0] {S_IDLE, S_WRITE, S_FETCH, S_LATCH, S_BUSY} lcdhrm_state_e;
    typedef logic [6:0] lcdhrm_addr_t;
endpackage

// ### hw/lcdhrm_ddram.sv
// display data memory, one host port and one refresh port
// assumes indices are computed by the core; out-of-range reads give zero
`timescale 1ns/1ps
`include "lcdhrm_map.svh"

module lcdhrm_ddram #(
    parameter int DEPTH = `LCDHRM_DD_DEPTH,
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             hostWe,
    input  wire logic [4:0]       hostIdx,
    input  wire logic [WIDTH-1:0] hostWdata,
    output      logic [WIDTH-1:0] hostRd_ff,
    input  wire logic [4:0]       refIdx,
    output      logic [WIDTH-1:0] refRd_ff
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (hostWe && hostIdx < DEPTH) begin
            mem[hostIdx] <= hostWdata;
        end
    end

    // separate ports: refresh never waits for or sees a half-done host access
    always_ff @(posedge clk) begin
        hostRd_ff <= (hostIdx < DEPTH) ? mem[hostIdx] : '0;
        refRd_ff  <= (refIdx < DEPTH) ? mem[refIdx] : '0;
    end
endmodule

// ### hw/lcdhrm_cgram.sv
// pattern memory with host port, refresh port and icon outputs
// assumes the core gates icon display; contents survive reset
`timescale 1ns/1ps
`include "lcdhrm_map.svh"

module lcdhrm_cgram #(
    parameter int DEPTH      = `LCDHRM_CG_DEPTH,
    parameter int WIDTH      = 5,
    parameter int ICON_BASE  = `LCDHRM_ICON_BASE,
    parameter int ICON_WORDS = `LCDHRM_ICON_WORDS
) (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic                        hostWe,
    input  wire logic [4:0]                  hostAddr,
    input  wire logic [WIDTH-1:0]            hostWdata,
    output      logic [WIDTH-1:0]            hostRd_ff,
    input  wire logic [4:0]                  refAddr,
    output      logic [WIDTH-1:0]            refRd_ff,
    input  wire logic                        iconShow,
    output      logic [ICON_WORDS*WIDTH-1:0] iconSeg_ff
);
    logic [WIDTH-1:0]            mem [DEPTH];
    logic [ICON_WORDS*WIDTH-1:0] iconNow;

    // no reset on the array: only software rewrites clear it
    always_ff @(posedge clk) begin
        if (hostWe) begin
            mem[hostAddr] <= hostWdata;
        end
    end

    always_ff @(posedge clk) begin
        hostRd_ff <= mem[hostAddr];
        refRd_ff  <= mem[refAddr];
    end

    // first icon word drives the top group of five segments
    genvar k;
    for (k = 0; k < ICON_WORDS; k++) begin : g_icon
        assign iconNow[(ICON_WORDS-1-k)*WIDTH +: WIDTH] = mem[ICON_BASE + k];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            iconSeg_ff <= '0;
        end else begin
            iconSeg_ff <= iconShow ? iconNow : '0;
        end
    end
endmodule

// ### hw/lcdhrm_core.sv
// host register and memory core of a 12x2 character display controller
// host pins arrive unsynchronised; refresh scan indices come from clk-domain driver timing
`timescale 1ns/1ps
`include "lcdhrm_map.svh"

module lcdhrm_core (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        registerSelect,
    input  wire logic        readWrite,
    input  wire logic        enableStrobe,
    input  wire logic [7:0]  dataIn,
    output      logic [7:0]  dataOut,
    output      logic        dataOeN,
    output      logic        busyFlag,
    input  wire logic        refreshLine,
    input  wire logic [3:0]  refreshPos,
    input  wire logic [2:0]  refreshRow,
    output      logic [4:0]  refreshDots,
    output      logic [59:0] iconSegments
);
    localparam int PINS = 11;

    logic [PINS-1:0]            pinS1_ff, pinS2_ff, pinS3_ff, pinSt_ff;
    logic                       ePrev_ff;
    logic                       eSt, rsSt, rwSt;
    logic [7:0]                 busSt;
    logic                       eRise, eFall, idle;
    logic                       cmdTake, datWrTake, datRdTake, opTake;
    logic                       isDdAddr, isCgAddr, isShift, isDisp, isEntry, isHome;
    lcdhrm_pkg::lcdhrm_state_e  state_ff;
    lcdhrm_pkg::lcdhrm_addr_t   ac_ff;
    logic [7:0]                 dr_ff;
    logic [7:0]                 dataOut_ff;
    logic                       drive_ff;
    logic                       cgSel_ff, inc_ff, entryShift_ff, dispOn_ff, cursorOn_ff;
    logic [3:0]                 shift_ff;
    logic [11:0]                busyCnt_ff;
    logic [11:0]                opCycles;
    logic                       ddValid;
    logic [4:0]                 ddIdx;
    logic [7:0]                 ddHostRd, ddRefCode;
    logic [4:0]                 cgHostRd, cgRefRow;
    logic [7:0]                 latchData;
    logic [4:0]                 refSum;
    logic [3:0]                 refLow;
    logic [4:0]                 refIdx;
    logic                       curHit;
    logic [2:0]                 p1Row_ff;
    logic                       p1Cur_ff;
    logic                       p2Cur_ff, p2Cg_ff;
    logic [4:0]                 p2Rom_ff;
    logic [4:0]                 dots_ff;

    // next counter value: pattern space wraps in 32, each display line hops to the other
    function automatic lcdhrm_pkg::lcdhrm_addr_t stepAddr(
        input lcdhrm_pkg::lcdhrm_addr_t a,
        input logic                     up,
        input logic                     cg
    );
        if (cg) begin
            stepAddr = {2'h0, up ? a[4:0] + 5'h01 : a[4:0] - 5'h01};
        end else if (up) begin
            stepAddr = (a[3:0] >= `LCDHRM_LINE_LAST) ? {~a[6], 6'h00} : a + 7'h01;
        end else begin
            stepAddr = (a[3:0] == 4'h0 || a[3:0] > `LCDHRM_LINE_LAST) ?
                       {~a[6], 2'h0, `LCDHRM_LINE_LAST} : a - 7'h01;
        end
    endfunction

    // display window offset within a line, left moves the window forward
    function automatic logic [3:0] rotate(input logic [3:0] s, input logic left);
        if (left) begin
            rotate = (s == `LCDHRM_LINE_LAST) ? 4'h0 : s + 4'h1;
        end else begin
            rotate = (s == 4'h0) ? `LCDHRM_LINE_LAST : s - 4'h1;
        end
    endfunction

    // stand-in glyph table; the real glyphs are a mask choice
    function automatic logic [4:0] romRow(input logic [7:0] code, input logic [2:0] row);
        romRow = (row == `LCDHRM_CURSOR_ROW) ? 5'h00 : (code[4:0] ^ {code[7:5], row[1:0]});
    endfunction

    // pin synchronisers, a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (reset) begin
            pinS1_ff <= '0;
            pinS2_ff <= '0;
            pinS3_ff <= '0;
            pinSt_ff <= '0;
            ePrev_ff <= 1'b0;
        end else begin
            pinS1_ff <= {enableStrobe, registerSelect, readWrite, dataIn};
            pinS2_ff <= pinS1_ff;
            pinS3_ff <= pinS2_ff;
            pinSt_ff <= (pinS3_ff & ~(pinS2_ff ^ pinS3_ff)) | (pinSt_ff & (pinS2_ff ^ pinS3_ff));
            ePrev_ff <= pinSt_ff[PINS-1];
        end
    end

    assign {eSt, rsSt, rwSt, busSt} = pinSt_ff;
    assign eRise = eSt & ~ePrev_ff;
    assign eFall = ~eSt & ePrev_ff;
    assign idle  = (state_ff == lcdhrm_pkg::S_IDLE);

    // host cycles end on the strobe's falling edge; nothing but status is taken while busy
    assign cmdTake   = eFall & ~rsSt & ~rwSt & idle & (busSt != 8'h00);
    assign datWrTake = eFall & rsSt & ~rwSt & idle;
    assign datRdTake = eFall & rsSt & rwSt & idle;
    assign opTake    = cmdTake | datWrTake | datRdTake;

    assign isDdAddr = (busSt >> `LCDHRM_OP_DDADDR) == 8'h01;
    assign isCgAddr = (busSt >> `LCDHRM_OP_CGADDR) == 8'h01;
    assign isShift  = (busSt >> `LCDHRM_OP_SHIFT) == 8'h01;
    assign isDisp   = (busSt >> `LCDHRM_OP_DISPCTL) == 8'h01;
    assign isEntry  = (busSt >> `LCDHRM_OP_ENTRY) == 8'h01;
    assign isHome   = (busSt >> `LCDHRM_OP_HOME) == 8'h01;

    always_comb begin
        opCycles = 12'(`LCDHRM_CYC_FAST);
        if (datRdTake || (cmdTake && isShift)) begin
            opCycles = 12'(`LCDHRM_CYC_SLOW);
        end
    end

    // busy lasts exactly the execution count from the cycle after the take
    always_ff @(posedge clk) begin
        if (reset) begin
            busyCnt_ff <= 12'h000;
        end else if (opTake) begin
            busyCnt_ff <= opCycles;
        end else if (busyCnt_ff != 12'h000) begin
            busyCnt_ff <= busyCnt_ff - 12'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= lcdhrm_pkg::S_IDLE;
        end else begin
            case (state_ff)
                lcdhrm_pkg::S_IDLE: begin
                    if (datWrTake) begin
                        state_ff <= lcdhrm_pkg::S_WRITE;
                    end else if (datRdTake || (cmdTake && (isDdAddr || isCgAddr))) begin
                        state_ff <= lcdhrm_pkg::S_FETCH;
                    end else if (cmdTake) begin
                        state_ff <= lcdhrm_pkg::S_BUSY;
                    end
                end
                lcdhrm_pkg::S_WRITE: state_ff <= lcdhrm_pkg::S_BUSY;
                lcdhrm_pkg::S_FETCH: state_ff <= lcdhrm_pkg::S_LATCH;
                lcdhrm_pkg::S_LATCH: state_ff <= lcdhrm_pkg::S_BUSY;
                lcdhrm_pkg::S_BUSY: begin
                    if (busyCnt_ff == 12'h001) begin
                        state_ff <= lcdhrm_pkg::S_IDLE;
                    end
                end
                default: state_ff <= lcdhrm_pkg::S_IDLE;
            endcase
        end
    end

    assign busyFlag = ~idle;

    always_ff @(posedge clk) begin
        if (reset) begin
            ac_ff <= `LCDHRM_RESET_AC;
        end else if (cmdTake && isDdAddr) begin
            ac_ff <= busSt[6:0];
        end else if (cmdTake && isCgAddr) begin
            ac_ff <= {2'h0, busSt[4:0]};
        end else if (cmdTake && isHome) begin
            ac_ff <= `LCDHRM_RESET_AC;
        end else if (cmdTake && isShift && !busSt[`LCDHRM_SC_BIT]) begin
            ac_ff <= stepAddr(ac_ff, busSt[`LCDHRM_RL_BIT], cgSel_ff);
        end else if (datRdTake || state_ff == lcdhrm_pkg::S_WRITE) begin
            ac_ff <= stepAddr(ac_ff, inc_ff, cgSel_ff);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cgSel_ff <= 1'b0;
        end else if (cmdTake && isDdAddr) begin
            cgSel_ff <= 1'b0;
        end else if (cmdTake && isCgAddr) begin
            cgSel_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            inc_ff        <= 1'b1;
            entryShift_ff <= 1'b0;
            dispOn_ff     <= 1'b0;
            cursorOn_ff   <= 1'b0;
        end else if (cmdTake && isEntry) begin
            inc_ff        <= busSt[1];
            entryShift_ff <= busSt[0];
        end else if (cmdTake && isDisp) begin
            dispOn_ff     <= busSt[2];
            cursorOn_ff   <= busSt[1];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            shift_ff <= 4'h0;
        end else if (cmdTake && isHome) begin
            shift_ff <= 4'h0;
        end else if (cmdTake && isShift && busSt[`LCDHRM_SC_BIT]) begin
            shift_ff <= rotate(shift_ff, ~busSt[`LCDHRM_RL_BIT]);
        end else if (state_ff == lcdhrm_pkg::S_WRITE && entryShift_ff && !cgSel_ff) begin
            shift_ff <= rotate(shift_ff, inc_ff);
        end
    end

    // data register: host byte in, RAM byte back after address set or read
    always_ff @(posedge clk) begin
        if (reset) begin
            dr_ff <= 8'h00;
        end else if (datWrTake) begin
            dr_ff <= busSt;
        end else if (state_ff == lcdhrm_pkg::S_LATCH) begin
            dr_ff <= latchData;
        end
    end

    // the command register is never placed on the bus, only status or data
    always_ff @(posedge clk) begin
        if (reset) begin
            drive_ff   <= 1'b0;
            dataOut_ff <= 8'h00;
        end else if (eRise && rwSt) begin
            drive_ff   <= 1'b1;
            dataOut_ff <= rsSt ? dr_ff : {busyFlag, ac_ff};
        end else if (eFall) begin
            drive_ff   <= 1'b0;
        end
    end

    assign dataOut = dataOut_ff;
    assign dataOeN = ~drive_ff;

    // host memory slot
    assign ddValid = (ac_ff[5:4] == 2'h0) && (ac_ff[3:0] <= `LCDHRM_LINE_LAST);
    assign ddIdx   = ac_ff[6] ? {1'b0, ac_ff[3:0]} + {1'b0, `LCDHRM_LINE_LEN} : {1'b0, ac_ff[3:0]};
    assign latchData = cgSel_ff ? {3'h0, cgHostRd} : (ddValid ? ddHostRd : 8'h00);

    lcdhrm_ddram #(
        .DEPTH (`LCDHRM_DD_DEPTH),
        .WIDTH (8)
    ) u_ddram (
        .clk       (clk),
        .hostWe    (state_ff == lcdhrm_pkg::S_WRITE && !cgSel_ff && ddValid),
        .hostIdx   (ddValid ? ddIdx : 5'h00),
        .hostWdata (dr_ff),
        .hostRd_ff (ddHostRd),
        .refIdx    (refIdx),
        .refRd_ff  (ddRefCode)
    );

    lcdhrm_cgram #(
        .DEPTH      (`LCDHRM_CG_DEPTH),
        .WIDTH      (5),
        .ICON_BASE  (`LCDHRM_ICON_BASE),
        .ICON_WORDS (`LCDHRM_ICON_WORDS)
    ) u_cgram (
        .clk        (clk),
        .reset      (reset),
        .hostWe     (state_ff == lcdhrm_pkg::S_WRITE && cgSel_ff),
        .hostAddr   (ac_ff[4:0]),
        .hostWdata  (dr_ff[4:0]),
        .hostRd_ff  (cgHostRd),
        .refAddr    ({ddRefCode[1:0], p1Row_ff}),
        .refRd_ff   (cgRefRow),
        .iconShow   (dispOn_ff),
        .iconSeg_ff (iconSegments)
    );

    // refresh slot: position plus window offset, wrapped within the line
    assign refSum = {1'b0, refreshPos} + {1'b0, shift_ff};
    assign refLow = (refSum >= {1'b0, `LCDHRM_LINE_LEN}) ? 4'(refSum - {1'b0, `LCDHRM_LINE_LEN}) : refSum[3:0];
    assign refIdx = refreshLine ? {1'b0, refLow} + {1'b0, `LCDHRM_LINE_LEN} : {1'b0, refLow};
    assign curHit = cursorOn_ff & ~cgSel_ff & (ac_ff == {refreshLine, 2'h0, refLow});

    always_ff @(posedge clk) begin
        if (reset) begin
            p1Row_ff <= 3'h0;
            p1Cur_ff <= 1'b0;
            p2Cur_ff <= 1'b0;
            p2Cg_ff  <= 1'b0;
            p2Rom_ff <= 5'h00;
            dots_ff  <= 5'h00;
        end else begin
            p1Row_ff <= refreshRow;
            p1Cur_ff <= curHit;
            p2Cur_ff <= p1Cur_ff & (p1Row_ff == `LCDHRM_CURSOR_ROW);
            p2Cg_ff  <= (ddRefCode[7:4] == 4'h0);
            p2Rom_ff <= romRow(ddRefCode, p1Row_ff);
            dots_ff  <= dispOn_ff ? ((p2Cg_ff ? cgRefRow : p2Rom_ff) | {5{p2Cur_ff}}) : 5'h00;
        end
    end

    assign refreshDots = dots_ff;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_status_read;
        eRise && !rsSt && rwSt |=> dataOut == {$past(busyFlag), $past(ac_ff)} && !dataOeN;
    endproperty
    a_status_read: assert property (p_status_read) else $error("status byte wrong");

    property p_busy_ignores;
        state_ff == lcdhrm_pkg::S_BUSY && busyCnt_ff > 12'h001 && eFall |=> $stable(ac_ff) && busyFlag;
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("request taken while busy");

    property p_busy_end;
        $fell(busyFlag) |-> $past(busyCnt_ff) == 12'h001;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy ended early or late");

    property p_busy_hold;
        opTake |=> busyFlag [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy not held after take");

    property p_addr_load;
        cmdTake && isDdAddr |=> ac_ff == $past(busSt[6:0]) && !cgSel_ff ##1 state_ff == lcdhrm_pkg::S_LATCH;
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address set did not load");

    property p_prefetch;
        state_ff == lcdhrm_pkg::S_LATCH |=> dr_ff === $past(latchData) && state_ff == lcdhrm_pkg::S_BUSY;
    endproperty
    a_prefetch: assert property (p_prefetch) else $error("data register not refilled");

    property p_read_refill;
        datRdTake |=> state_ff == lcdhrm_pkg::S_FETCH ##1 state_ff == lcdhrm_pkg::S_LATCH;
    endproperty
    a_read_refill: assert property (p_read_refill) else $error("no prefetch after read");

    property p_line_hop;
        datRdTake && inc_ff && !cgSel_ff && ac_ff == 7'h0B |=> ac_ff == 7'h40;
    endproperty
    a_line_hop: assert property (p_line_hop) else $error("line one end did not hop");

    property p_cg_down;
        state_ff == lcdhrm_pkg::S_WRITE && !inc_ff && cgSel_ff && ac_ff == 7'h00 |=> ac_ff == 7'h1F;
    endproperty
    a_cg_down: assert property (p_cg_down) else $error("decrement wrap wrong");

    property p_shift_wrap;
        cmdTake && isShift && busSt[3] && !busSt[2] && shift_ff == 4'hB |=> shift_ff == 4'h0;
    endproperty
    a_shift_wrap: assert property (p_shift_wrap) else $error("left shift did not wrap");

    property p_icon_dark;
        !dispOn_ff |=> iconSegments == 60'h0;
    endproperty
    a_icon_dark: assert property (p_icon_dark) else $error("icons lit while display off");

    property p_drive_read;
        !dataOeN |-> rwSt;
    endproperty
    a_drive_read: assert property (p_drive_read) else $error("bus driven on write");

    c_data_write: cover property (datWrTake ##1 state_ff == lcdhrm_pkg::S_WRITE);
    c_busy_poll:  cover property (eRise && !rsSt && rwSt && busyFlag);
    c_disp_shift: cover property (cmdTake && isShift && busSt[3]);
    c_cursor_lit: cover property (p2Cur_ff && dispOn_ff);
endmodule

// ### verif/lcdhrm_host.sv
// host model: eight-bit accesses with setup and hold around the strobe
// assumes the core syncs its pins on clk and that the bench resolves the bus
`timescale 1ns/1ps
module lcdhrm_host (
    input  wire logic       clk,
    input  wire logic       busyFlag,
    output      logic       registerSelect,
    output      logic       readWrite,
    output      logic       enableStrobe,
    output      logic [7:0] hostData
);
    initial begin
        registerSelect = 1'b0;
        readWrite = 1'b1;
        enableStrobe = 1'b0;
        hostData = 8'h00;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    // released bus shows the inverse of its last value
    task automatic access(input logic rs, input logic rw, input logic [7:0] d);
        cyc(1);
        registerSelect = rs;
        readWrite = rw;
        hostData = rw ? ~hostData : d;
        cyc(6);
        enableStrobe = 1'b1;
        cyc(10);
        enableStrobe = 1'b0;
        cyc(8);
    endtask
    // no new access until the busy flag has dropped
    task automatic waitIdle();
        int n;
        n = 0;
        while (busyFlag !== 1'b0 && n < 4000) begin
            cyc(1);
            n++;
        end
    endtask
endmodule

// ### verif/tb_lcdhrm_core.sv
// bench of the display host core: host model, queued expectations, watchers
// assumes a 20 MHz clock and the core's synchronous active-high reset
`timescale 1ns/1ps
module tb_lcdhrm_core;
    logic clk, reset, rs, rw, en, busy, oeN;
    logic [7:0] hostData, din, dout;
    logic [59:0] icons;
    logic [11:0] expQ[$], busyQ[$];
    logic [7:0] rv[5];
    logic refLine;
    logic [3:0] refPos;
    logic [2:0] refRow;
    logic [4:0] dots;
    int error_cnt, n_compared, bc, seed;
    assign din = oeN ? hostData : dout;
    lcdhrm_host host (.clk(clk), .busyFlag(busy), .registerSelect(rs), .readWrite(rw),
        .enableStrobe(en), .hostData(hostData));
    lcdhrm_core DUT (.clk(clk), .reset(reset), .registerSelect(rs), .readWrite(rw), .enableStrobe(en),
        .dataIn(din), .dataOut(dout), .dataOeN(oeN), .busyFlag(busy), .refreshLine(refLine),
        .refreshPos(refPos), .refreshRow(refRow), .refreshDots(dots), .iconSegments(icons));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input string what, input logic [11:0] e, input logic [11:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic close_out();
        if (expQ.size() + busyQ.size() != 0) begin
            error_cnt++;
            $display("Error pending results expected %0d seen %0d", 0, expQ.size() + busyQ.size());
        end
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // refresh scan: dots of one cell row appear three edges after the index
    task automatic scan(input logic l, input logic [3:0] p, input logic [2:0] r, input logic [4:0] e);
        refLine = l;
        refPos = p;
        refRow = r;
        repeat (4) @(posedge clk);
        #1;
        check("refresh dots", {7'h00, e}, {7'h00, dots});
    endtask
    task automatic op(input logic s, input logic w, input logic [7:0] d, input int b, input bit wt = 1);
        if (w) expQ.push_back({4'h0, d});
        if (b > 0) busyQ.push_back(b[11:0]);
        host.access(s, w, d);
        if (wt) host.waitIdle();
    endtask
    always @(negedge oeN) begin
        #1;
        check("read data", expQ.size() ? expQ.pop_front() : 12'hFFF, {4'h0, dout});
    end
    always @(posedge clk) begin
        if (busy === 1'b1) bc++;
        else if (bc > 0) begin
            check("busy cycles", busyQ.size() ? busyQ.pop_front() : 12'h000, bc[11:0]);
            bc = 0;
        end
    end
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        close_out();
    end
    initial begin
        reset = 1'b1;
        refLine = 1'b0;
        refPos = 4'h0;
        refRow = 3'h0;
        seed = 32'hD4B2B724;
        foreach (rv[i]) rv[i] = 8'($random(seed));
        repeat (8) @(posedge clk);
        #5 reset = 1'b0;
        op(0, 1, 8'h00, 0);
        op(0, 0, 8'h06, 2500);
        op(0, 0, 8'h8A, 2500);
        op(1, 0, rv[0], 2500);
        op(1, 0, rv[1], 2500);
        op(0, 1, 8'h40, 0);
        op(0, 0, 8'h8A, 2500, 0);
        op(0, 1, 8'h8A, 0, 0);
        op(1, 0, ~rv[0], 0);
        op(0, 1, 8'h0A, 0);
        op(1, 1, rv[0], 3500);
        op(1, 1, rv[1], 3500);
        op(0, 1, 8'h40, 0);
        op(0, 0, 8'h04, 2500);
        op(0, 0, 8'h80, 2500);
        op(1, 0, rv[2], 2500);
        op(0, 1, 8'h4B, 0);
        op(0, 0, 8'h0C, 2500);
        op(0, 0, 8'h54, 2500);
        op(1, 0, rv[3], 2500);
        check("icon word", {7'h00, rv[3][4:0]}, {7'h00, icons[59:55]});
        op(0, 0, 8'h42, 2500);
        op(1, 0, rv[4], 2500);
        op(0, 0, 8'h81, 2500);
        op(1, 0, 8'h04, 2500);
        scan(1'b0, 4'h1, 3'h2, rv[4][4:0]);
        op(0, 0, 8'h18, 3500);
        scan(1'b0, 4'h0, 3'h2, rv[4][4:0]);
        op(0, 0, 8'h0E, 2500);
        scan(1'b0, 4'hB, 3'h7, 5'h1F);
        repeat (4) @(posedge clk);
        close_out();
    end
endmodule
